// >>> iepc_pkg.sv
// constants for the interrupt enable and priority controller
package iepc_pkg;
   localparam int unsigned NUM_SRC = 12;
   localparam int unsigned NUM_PAIR = 6;
   localparam int unsigned NUM_FLAG = 14;
   // register addresses on the special function register port
   localparam logic [7:0] ADDR_EN_A = 8'ha8;
   localparam logic [7:0] ADDR_PRIO_LO = 8'ha9;
   localparam logic [7:0] ADDR_EN_B = 8'hb8;
   localparam logic [7:0] ADDR_PRIO_HI = 8'hb9;
   // reset values
   localparam logic [7:0] RST_EN_A = 8'h00;
   localparam logic [7:0] RST_EN_B = 8'h00;
   localparam logic [5:0] RST_PRIO = 6'h00;
   // bit positions
   localparam int unsigned BIT_GLOBAL_GATE = 7;
   localparam int unsigned BIT_WATCHDOG_KICK = 6;
   localparam int unsigned BIT_WATCHDOG_START = 6;
   localparam int unsigned BIT_RELOAD_EN = 7;
   localparam int unsigned BIT_WATCHDOG_STATUS = 6;
   localparam logic [7:0] MASK_EN_A = 8'hbf;
   localparam logic [7:0] MASK_EN_B = 8'hbf;
   // request flag inputs, index into req_flags
   localparam int unsigned FL_EXT0 = 0;
   localparam int unsigned FL_TMR0 = 1;
   localparam int unsigned FL_EXT1 = 2;
   localparam int unsigned FL_TMR1 = 3;
   localparam int unsigned FL_URX = 4;
   localparam int unsigned FL_UTX = 5;
   localparam int unsigned FL_TMR2 = 6;
   localparam int unsigned FL_RELOAD = 7;
   localparam int unsigned FL_ADC = 8;
   localparam int unsigned FL_EXT2 = 9;
   // vectors: left member base, right member base, stride per pair
   localparam logic [15:0] VEC_LEFT_BASE = 16'h0003;
   localparam logic [15:0] VEC_RIGHT_BASE = 16'h0043;
   localparam int unsigned VEC_STRIDE_SHIFT = 3;
   localparam logic [15:0] VEC_FIRST = 16'h0003;
   localparam logic [15:0] VEC_LAST = 16'h006b;
endpackage

// >>> iepc_res_if.sv
// request and result bundle between controller and priority resolver
`timescale 1ns/10ps
interface iepc_res_if;
   import iepc_pkg::*;
   logic [NUM_SRC-1:0] req;
   logic [1:0] pair_lvl [NUM_PAIR];
   logic found;
   logic [3:0] win;
   logic [1:0] win_lvl;
   modport resolver (input req, input pair_lvl, output found, output win, output win_lvl);
   modport ctrl (output req, output pair_lvl, input found, input win, input win_lvl);
endinterface

// >>> iepc_resolver.sv
// priority resolver over twelve gated requests: highest pair level first, then fixed polling order
`timescale 1ns/10ps
module iepc_resolver import iepc_pkg::*; (
   input wire logic clk,
   input wire logic arst_n,
   iepc_res_if.resolver rif
);
   logic found;
   logic [3:0] win;
   logic [1:0] win_lvl;
   logic [1:0] max_lvl;
   logic any_req;

   // walk in polling order: pair 0 first, left member before right
   always_comb begin
      found = 1'b0;
      win = 4'h0;
      win_lvl = 2'h0;
      for (int k = 0; k < NUM_SRC; k++) begin
         if (rif.req[k] && (!found || rif.pair_lvl[k/2] > win_lvl)) begin // [RULE11] [RULE12] [RULE13]
            found = 1'b1;
            win = 4'(k);
            win_lvl = rif.pair_lvl[k/2];
         end
      end
   end

   assign rif.found = found;
   assign rif.win = win;
   assign rif.win_lvl = win_lvl;

   // helper only for checking
   always_comb begin
      max_lvl = 2'h0;
      any_req = |rif.req;
      for (int k = 0; k < NUM_SRC; k++) begin
         if (rif.req[k] && rif.pair_lvl[k/2] > max_lvl) begin
            max_lvl = rif.pair_lvl[k/2];
         end
      end
   end

   AST_HIGHEST_LEVEL: assert property (@(posedge clk) disable iff (!arst_n) // [RULE11]
      any_req |-> (found && win_lvl == max_lvl))
      else $error("winner is not from the highest pending level");
   AST_LEFT_FIRST: assert property (@(posedge clk) disable iff (!arst_n) // [RULE13]
      (rif.req[0] && rif.pair_lvl[0] == max_lvl) |-> win == 4'h0)
      else $error("left member of first pair lost a tie");
endmodule

// >>> iepc_ctrl.sv
// interrupt enable, priority and nesting control for the core
// Notes on behaviour
// RULE1: global gate zero blocks every interrupt; otherwise each source uses its enable.
// RULE2: enable A bits 0-4 gate line0, timer0, line1, timer1, serial.
// RULE3: enable A bit 5 gates timer2 overflow and reload together.
// RULE4: writing one to enable A bit 6 kicks the watchdog; no interrupt gate.
// RULE5: enable B bits 0-5 gate ADC and lines 2 to 6.
// RULE6: writing one to enable B bit 6 starts or restarts the watchdog.
// RULE7: enable B bit 7 masks only the timer2 reload request.
// RULE8: pair level is high bit n over low bit n, 3 highest.
// RULE9: priority bits 0-5 map pairs line0/ADC through timer2/line6.
// RULE10: only a strictly higher level preempts; level 3 never preempted.
// RULE11: among different levels pending together, the highest level wins.
// RULE12: same-level ties resolved by pair order, line0 pair first.
// RULE13: within a pair the left source wins a tie.
// RULE14: polling order never lets an equal level preempt.
// RULE15: low priority bit 6 shows watchdog status; other top bits reserved.
// RULE16: flags sampled once per machine cycle, polled next; no memory.
// RULE17: vectoring deferred one more instruction after return or register write.
// RULE18: vector call goes to per-source address 0003h through 006bh.
// RULE19: enables and priorities reset to zero.
`timescale 1ns/10ps
module iepc_ctrl import iepc_pkg::*; (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   input wire logic [NUM_FLAG-1:0] req_flags,
   input wire logic mc_strobe,
   input wire logic instr_final,
   input wire logic return_from_irq,
   input wire logic watchdog_status_flag,
   output logic vector_call,
   output logic [15:0] vector_addr,
   output logic [3:0] vector_src,
   output logic [3:0] in_service,
   output logic watchdog_kick,
   output logic watchdog_start
);
   iepc_res_if rif ();

   logic [7:0] irq_enable_reg_a_q;
   logic [7:0] irq_enable_reg_b_q;
   logic [5:0] prio_lo_q;
   logic [5:0] prio_hi_q;
   logic [NUM_FLAG-1:0] samp_q;
   logic [3:0] active_q;
   logic defer_q;
   logic [7:0] rdata_q;
   logic call_q;
   logic [15:0] vec_q;
   logic [3:0] src_q;
   logic kick_q;
   logic start_q;

   // register decode
   wire wr_en_a = sfr_wr && (sfr_addr == ADDR_EN_A);
   wire wr_en_b = sfr_wr && (sfr_addr == ADDR_EN_B);
   wire wr_lo = sfr_wr && (sfr_addr == ADDR_PRIO_LO);
   wire wr_hi = sfr_wr && (sfr_addr == ADDR_PRIO_HI);
   wire wr_any = wr_en_a || wr_en_b || wr_lo || wr_hi;

   wire global_irq_gate = irq_enable_reg_a_q[BIT_GLOBAL_GATE];
   wire reload_irq_enable = irq_enable_reg_b_q[BIT_RELOAD_EN];

   // combined sources from the sampled flags
   wire [NUM_SRC-1:0] src_raw;
   assign src_raw[0] = samp_q[FL_EXT0];
   assign src_raw[2] = samp_q[FL_TMR0];
   assign src_raw[4] = samp_q[FL_EXT1];
   assign src_raw[6] = samp_q[FL_TMR1];
   assign src_raw[8] = samp_q[FL_URX] | samp_q[FL_UTX];
   // reload flag itself keeps counting elsewhere; only its request is masked
   assign src_raw[10] = samp_q[FL_TMR2] | (samp_q[FL_RELOAD] & reload_irq_enable); // [RULE3] [RULE7]

   // per-source enable, left members from enable A, right from enable B
   wire [NUM_SRC-1:0] src_en;
   genvar p;
   generate
      for (p = 0; p < NUM_PAIR; p++) begin : g_pair
         assign src_raw[2*p+1] = samp_q[FL_ADC+p]; // [RULE5]
         assign src_en[2*p] = irq_enable_reg_a_q[p]; // [RULE2] [RULE3]
         assign src_en[2*p+1] = irq_enable_reg_b_q[p]; // [RULE5]
         assign rif.pair_lvl[p] = {prio_hi_q[p], prio_lo_q[p]}; // [RULE8] [RULE9]
      end
   endgenerate

   assign rif.req = global_irq_gate ? (src_raw & src_en) : '0; // [RULE1]

   function automatic logic [2:0] top_active(input logic [3:0] act);
      logic [2:0] r;
      r = 3'h0;
      for (int i = 0; i < 4; i++) begin
         if (act[i]) begin
            r = {1'b1, 2'(i)};
         end
      end
      return r;
   endfunction

   wire [2:0] cur = top_active(active_q);
   wire cur_busy = cur[2];
   wire [1:0] cur_lvl = cur[1:0];

   // strict compare: an equal level never preempts, level 3 never exceeded
   wire lvl_ok = !cur_busy || (rif.win_lvl > cur_lvl); // [RULE10] [RULE14]
   wire block_now = defer_q || wr_any || return_from_irq; // [RULE17]
   wire fire = mc_strobe && instr_final && rif.found && lvl_ok && !block_now; // [RULE16]

   // vector: pairs are 8 bytes apart, right members start at a second base
   wire [15:0] vec_base = rif.win[0] ? VEC_RIGHT_BASE : VEC_LEFT_BASE;
   wire [15:0] vec_ofs = 16'(rif.win[3:1]) << VEC_STRIDE_SHIFT;
   wire [15:0] vec_d = vec_base + vec_ofs; // [RULE18]

   wire [3:0] top_onehot = cur_busy ? (4'h1 << cur_lvl) : 4'h0;
   wire [3:0] act_d = fire ? (active_q | (4'h1 << rif.win_lvl))
                      : (return_from_irq ? (active_q & ~top_onehot) : active_q);

   // read mux; watchdog control bits do not hold and read as zero
   wire [7:0] rdata_d = (sfr_addr == ADDR_EN_A) ? irq_enable_reg_a_q
                      : (sfr_addr == ADDR_EN_B) ? irq_enable_reg_b_q
                      : (sfr_addr == ADDR_PRIO_LO) ? {1'b0, watchdog_status_flag, prio_lo_q} // [RULE15]
                      : (sfr_addr == ADDR_PRIO_HI) ? {2'b00, prio_hi_q} // [RULE15]
                      : 8'h00;

   iepc_resolver u_res (
      .clk(clk),
      .arst_n(arst_n),
      .rif(rif)
   );

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         irq_enable_reg_a_q <= RST_EN_A; // [RULE19]
         irq_enable_reg_b_q <= RST_EN_B; // [RULE19]
         prio_lo_q <= RST_PRIO; // [RULE19]
         prio_hi_q <= RST_PRIO; // [RULE19]
      end else begin
         if (wr_en_a) begin
            irq_enable_reg_a_q <= sfr_wdata & MASK_EN_A;
         end
         if (wr_en_b) begin
            irq_enable_reg_b_q <= sfr_wdata & MASK_EN_B;
         end
         if (wr_lo) begin
            prio_lo_q <= sfr_wdata[5:0];
         end
         if (wr_hi) begin
            prio_hi_q <= sfr_wdata[5:0];
         end
      end
   end

   // samples are fresh each machine cycle, nothing latched across polls
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         samp_q <= '0;
      end else if (mc_strobe) begin
         samp_q <= req_flags; // [RULE16]
      end
   end

   // defer holds until the current instruction has finished
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         defer_q <= 1'b0;
      end else if (wr_any || return_from_irq) begin
         defer_q <= 1'b1; // [RULE17]
      end else if (mc_strobe && instr_final) begin
         defer_q <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         active_q <= 4'h0;
         call_q <= 1'b0;
         vec_q <= 16'h0000;
         src_q <= 4'h0;
      end else begin
         active_q <= act_d; // [RULE10]
         call_q <= fire;
         if (fire) begin
            vec_q <= vec_d; // [RULE18]
            src_q <= rif.win;
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata_q <= 8'h00;
         kick_q <= 1'b0;
         start_q <= 1'b0;
      end else begin
         rdata_q <= rdata_d;
         kick_q <= wr_en_a && sfr_wdata[BIT_WATCHDOG_KICK]; // [RULE4]
         start_q <= wr_en_b && sfr_wdata[BIT_WATCHDOG_START]; // [RULE6]
      end
   end

   assign sfr_rdata = rdata_q;
   assign vector_call = call_q;
   assign vector_addr = vec_q;
   assign vector_src = src_q;
   assign in_service = active_q;
   assign watchdog_kick = kick_q;
   assign watchdog_start = start_q;

   AST_GATE_OFF: assert property (@(posedge clk) disable iff (!arst_n) // [RULE1]
      call_q |-> $past(global_irq_gate))
      else $error("call issued with global gate off");
   AST_WATCHDOG_KICK: assert property (@(posedge clk) disable iff (!arst_n) // [RULE4]
      (wr_en_a && sfr_wdata[BIT_WATCHDOG_KICK]) |=> kick_q)
      else $error("watchdog kick missing");
   AST_WATCHDOG_START: assert property (@(posedge clk) disable iff (!arst_n) // [RULE6]
      start_q |-> $past(wr_en_b && sfr_wdata[BIT_WATCHDOG_START]))
      else $error("watchdog start without write");
   AST_NO_PREEMPT: assert property (@(posedge clk) disable iff (!arst_n) // [RULE10]
      call_q |-> ($past(!cur_busy) || $past(rif.win_lvl) > $past(cur_lvl)))
      else $error("call did not exceed level in service");
   AST_TOP_LEVEL: assert property (@(posedge clk) disable iff (!arst_n) // [RULE10]
      $past(active_q[3]) && !$past(return_from_irq) |-> !call_q)
      else $error("level 3 routine preempted");
   AST_DEFER: assert property (@(posedge clk) disable iff (!arst_n) // [RULE17]
      (return_from_irq || wr_any) |=> !call_q ##1 (!call_q || $past(mc_strobe && instr_final, 2)))
      else $error("call not deferred");
   AST_STATUS_READ: assert property (@(posedge clk) disable iff (!arst_n) // [RULE15]
      (sfr_addr == ADDR_PRIO_LO) |=> sfr_rdata[BIT_WATCHDOG_STATUS] == $past(watchdog_status_flag))
      else $error("watchdog status not shown");
   AST_VEC_RANGE: assert property (@(posedge clk) disable iff (!arst_n) // [RULE18]
      call_q |-> (vec_q >= VEC_FIRST && vec_q <= VEC_LAST && vec_q[2:0] == 3'h3))
      else $error("vector out of range");
   AST_POLL_PHASE: assert property (@(posedge clk) disable iff (!arst_n) // [RULE16]
      call_q |-> $past(mc_strobe && instr_final))
      else $error("call outside final poll");
   AST_RELOAD_MASK: assert property (@(posedge clk) disable iff (!arst_n) // [RULE7]
      (!reload_irq_enable && !samp_q[FL_TMR2]) |-> !rif.req[10])
      else $error("reload request not masked");

   COV_CALL: cover property (@(posedge clk) disable iff (!arst_n) call_q);
   COV_NEST: cover property (@(posedge clk) disable iff (!arst_n) call_q && cur_busy);
   COV_RETURN: cover property (@(posedge clk) disable iff (!arst_n) return_from_irq && cur_busy);
   COV_TOP_LEVEL: cover property (@(posedge clk) disable iff (!arst_n) active_q[3]);
   COV_DEFER_BLOCK: cover property (@(posedge clk) disable iff (!arst_n)
      defer_q && mc_strobe && instr_final && rif.found);

   // register side
   AST_RESET_ZERO: assert property (@(posedge clk) disable iff (!arst_n) // [RULE19]
      !$past(arst_n) |-> (irq_enable_reg_a_q == RST_EN_A && irq_enable_reg_b_q == RST_EN_B
         && prio_lo_q == RST_PRIO && prio_hi_q == RST_PRIO))
      else $error("registers not cleared by reset");
   AST_EN_A_WRITE: assert property (@(posedge clk) disable iff (!arst_n) // [RULE2]
      wr_en_a |=> irq_enable_reg_a_q == ($past(sfr_wdata) & MASK_EN_A))
      else $error("enable A write not stored");
   AST_EN_B_WRITE: assert property (@(posedge clk) disable iff (!arst_n) // [RULE5]
      wr_en_b |=> irq_enable_reg_b_q == ($past(sfr_wdata) & MASK_EN_B))
      else $error("enable B write not stored");
   AST_KICK_NOT_HELD: assert property (@(posedge clk) disable iff (!arst_n) // [RULE4] [RULE6]
      !irq_enable_reg_a_q[BIT_WATCHDOG_KICK] && !irq_enable_reg_b_q[BIT_WATCHDOG_START])
      else $error("watchdog control bit held");
   AST_KICK_PULSE: assert property (@(posedge clk) disable iff (!arst_n) // [RULE4]
      kick_q |-> $past(wr_en_a && sfr_wdata[BIT_WATCHDOG_KICK]))
      else $error("watchdog kick without write");
   AST_HI_RESERVED: assert property (@(posedge clk) disable iff (!arst_n) // [RULE15]
      (sfr_addr == ADDR_PRIO_HI) |=> sfr_rdata[7:6] == 2'b00)
      else $error("reserved priority bits not zero");

   // request side
   AST_GATE_BLOCKS_ALL: assert property (@(posedge clk) disable iff (!arst_n) // [RULE1]
      !global_irq_gate |-> !rif.found)
      else $error("request passed with global gate off");
   AST_RIGHT_MAP: assert property (@(posedge clk) disable iff (!arst_n) // [RULE5]
      rif.req[1] |-> (samp_q[FL_ADC] && irq_enable_reg_b_q[0]))
      else $error("converter request without its enable");
   AST_TIMER2_MAP: assert property (@(posedge clk) disable iff (!arst_n) // [RULE3]
      rif.req[10] |-> (irq_enable_reg_a_q[5] && (samp_q[FL_TMR2] || samp_q[FL_RELOAD])))
      else $error("timer2 request without its enable");
   AST_RELOAD_PASSES: assert property (@(posedge clk) disable iff (!arst_n) // [RULE7]
      (global_irq_gate && irq_enable_reg_a_q[5] && reload_irq_enable && samp_q[FL_RELOAD])
      |-> rif.req[10])
      else $error("enabled reload request lost");
   AST_SAMPLE_FRESH: assert property (@(posedge clk) disable iff (!arst_n) // [RULE16]
      mc_strobe |=> samp_q == $past(req_flags))
      else $error("flags not resampled");

   // nesting side
   AST_LEVEL_RECORDED: assert property (@(posedge clk) disable iff (!arst_n) // [RULE8]
      fire |=> active_q[$past(rif.win_lvl)])
      else $error("level of new routine not recorded");
   AST_EQUAL_WAITS: assert property (@(posedge clk) disable iff (!arst_n) // [RULE14]
      (cur_busy && rif.win_lvl <= cur_lvl) |-> !fire)
      else $error("equal or lower level preempted");
   AST_RETURN_POPS: assert property (@(posedge clk) disable iff (!arst_n) // [RULE10]
      (return_from_irq && cur_busy) |=> !active_q[$past(cur_lvl)])
      else $error("return did not end top routine");
   AST_SRC_RANGE: assert property (@(posedge clk) disable iff (!arst_n) // [RULE18]
      call_q |-> src_q < 4'(NUM_SRC))
      else $error("source index out of range");
endmodule

// >>> iepc_core_model.sv
// machine cycle sequencer and watchdog view standing in for the core
`timescale 1ns/10ps
module iepc_core_model (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic watchdog_kick,
   input wire logic watchdog_start,
   output logic mc_strobe,
   output logic instr_final
);
   logic [1:0] phase_q;
   logic wd_run_q;
   logic [15:0] wd_age_q;
   // strobe every fourth clock; two-cycle instructions so polls get blocked too
   always @(negedge clk or negedge arst_n) begin
      if (!arst_n) begin
         phase_q <= 2'h0;
         mc_strobe <= 1'b0;
         instr_final <= 1'b0;
      end else begin
         phase_q <= phase_q + 2'h1;
         mc_strobe <= (phase_q == 2'h3);
         if (mc_strobe) begin
            instr_final <= ~instr_final;
         end
      end
   end
   // start sets running, kick or start clears age; no timeout action here
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wd_run_q <= 1'b0;
         wd_age_q <= 16'h0000;
      end else begin
         if (watchdog_start) begin
            wd_run_q <= 1'b1;
         end
         if (watchdog_kick || watchdog_start) begin
            wd_age_q <= 16'h0000;
         end else if (wd_run_q) begin
            wd_age_q <= wd_age_q + 16'h0001;
         end
      end
   end
endmodule

// >>> tb_top.sv
// self-checking bench for the interrupt enable and priority controller
`timescale 1ns/10ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin fail_count++; \
   $display("BAD %0t got %h exp %h", $time, a, e); end end
module tb_top;
   import iepc_pkg::*;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic [7:0] sfr_addr = 8'h00;
   logic sfr_wr = 1'b0;
   logic [7:0] sfr_wdata = 8'h00;
   logic [NUM_FLAG-1:0] req_flags = '0;
   logic return_from_irq = 1'b0;
   logic wd_status = 1'b0;
   logic [7:0] sfr_rdata;
   logic mc_strobe, instr_final, vector_call, watchdog_kick, watchdog_start;
   logic [15:0] vector_addr;
   logic [3:0] vector_src, in_service;
   int fail_count = 0;
   int samples_checked = 0;
   iepc_ctrl iepc_ctrl_inst (.clk(clk), .arst_n(arst_n), .sfr_addr(sfr_addr),
      .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .req_flags(req_flags),
      .mc_strobe(mc_strobe), .instr_final(instr_final), .return_from_irq(return_from_irq),
      .watchdog_status_flag(wd_status), .vector_call(vector_call),
      .vector_addr(vector_addr), .vector_src(vector_src), .in_service(in_service),
      .watchdog_kick(watchdog_kick), .watchdog_start(watchdog_start));
   iepc_core_model iepc_core_model_inst (.clk(clk), .arst_n(arst_n),
      .watchdog_kick(watchdog_kick), .watchdog_start(watchdog_start),
      .mc_strobe(mc_strobe), .instr_final(instr_final));
   initial begin
      forever #25 clk = ~clk;
   end
   task automatic end_sim();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // idle cycle first keeps back-to-back strobes apart; returns after the taking edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(negedge clk);
      sfr_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      sfr_addr = a;
      @(negedge clk);
      `CHK(sfr_rdata, e)
   endtask
   // bounded wait for a call, then its vector
   task automatic wcall(input logic [15:0] e);
      int i;
      i = 0;
      while (vector_call !== 1'b1 && i < 80) begin
         @(negedge clk);
         i++;
      end
      if (vector_call !== 1'b1) begin
         fail_count++;
         $display("BAD %0t no vector call", $time);
         end_sim();
      end else begin
         `CHK(vector_addr, e)
         @(negedge clk);
      end
   endtask
   task automatic nocall();
      int n;
      n = 0;
      repeat (80) begin
         @(negedge clk);
         if (vector_call !== 1'b0) n++;
      end
      `CHK(n, 0)
   endtask
   task automatic ret();
      @(negedge clk);
      return_from_irq = 1'b1;
      @(negedge clk);
      return_from_irq = 1'b0;
   endtask
   // per-flag vector: the two serial flags share one, as do timer2 and reload; right members start at 0043
   function automatic logic [15:0] vec(input int i);
      if (i < 4) return 16'(16'h0003 + 8 * i);
      if (i < 8) return (i < 6) ? 16'h0023 : 16'h002b;
      return 16'(16'h0043 + 8 * (i - 8));
   endfunction
   // per-flag source index: two per pair, left member even
   function automatic logic [3:0] src(input int i);
      if (i < 4) return 4'(2 * i);
      if (i < 8) return (i < 6) ? 4'h8 : 4'ha;
      return 4'(2 * (i - 8) + 1);
   endfunction
   initial begin
      repeat (12) @(negedge clk);
      arst_n = 1'b1;
      @(negedge clk);
      rd(ADDR_EN_A, 8'h00);
      rd(ADDR_EN_B, 8'h00);
      rd(ADDR_PRIO_LO, 8'h00);
      rd(ADDR_PRIO_HI, 8'h00);
      wr(ADDR_EN_A, 8'hff);
      `CHK(watchdog_kick, 1'b1)
      rd(ADDR_EN_A, 8'hbf);
      wr(ADDR_EN_B, 8'hff);
      `CHK(watchdog_start, 1'b1)
      rd(ADDR_EN_B, 8'hbf);
      `CHK(iepc_core_model_inst.wd_run_q, 1'b1)
      wd_status = 1'b1;
      wr(ADDR_PRIO_LO, 8'hff);
      rd(ADDR_PRIO_LO, 8'h7f);
      wd_status = 1'b0;
      wr(ADDR_PRIO_HI, 8'hff);
      rd(ADDR_PRIO_HI, 8'h3f);
      wr(8'h10, 8'hff);
      rd(8'h10, 8'h00);
      $display("test done: registers");
      for (int i = 0; i < NUM_FLAG; i++) begin
         req_flags = NUM_FLAG'(1) << i;
         wcall(vec(i));
         `CHK(vector_src, src(i))
         req_flags = '0;
         ret();
      end
      $display("test done: each source");
      wr(ADDR_EN_B, 8'h3f);
      req_flags[FL_RELOAD] = 1'b1;
      nocall();
      req_flags = '0;
      wr(ADDR_EN_A, 8'h9f);
      req_flags[FL_TMR2] = 1'b1;
      nocall();
      req_flags = '0;
      wr(ADDR_EN_A, 8'h3f);
      req_flags[FL_EXT0] = 1'b1;
      nocall();
      req_flags = '0;
      wr(ADDR_EN_A, 8'hff);
      nocall();
      wr(ADDR_EN_B, 8'hff);
      $display("test done: gating");
      wr(ADDR_PRIO_LO, 8'h00);
      wr(ADDR_PRIO_HI, 8'h00);
      req_flags = '1;
      wcall(16'h0003);
      req_flags[FL_EXT0] = 1'b0;
      nocall();
      ret();
      wcall(16'h0043);
      `CHK(vector_src, 4'h1)
      req_flags = '0;
      ret();
      $display("test done: polling order");
      // pair0 level 1, pair5 level 2
      wr(ADDR_PRIO_LO, 8'h01);
      wr(ADDR_PRIO_HI, 8'h20);
      req_flags = (NUM_FLAG'(1) << FL_EXT0) | (NUM_FLAG'(1) << FL_TMR2);
      wcall(16'h002b);
      `CHK(in_service, 4'h4)
      nocall();
      // pair1 raised to level 3 preempts the level 2 routine
      wr(ADDR_PRIO_LO, 8'h03);
      wr(ADDR_PRIO_HI, 8'h22);
      req_flags[FL_TMR0] = 1'b1;
      wcall(16'h000b);
      `CHK(in_service, 4'hc)
      wr(ADDR_PRIO_HI, 8'h23);
      nocall();
      req_flags = '0;
      ret();
      ret();
      $display("test done: levels");
      end_sim();
   end
endmodule
